// ### hw/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_CTRL_OFS        8'hD8
`define WDT_BIT_RESTART     0
`define WDT_BIT_RST_EN      1
`define WDT_BIT_CAUSE       2
`define WDT_BIT_IRQ_FLAG    3
`define WDT_BIT_SEL_LO      6
`define WDT_BIT_SEL_HI      7
`define WDT_SEL_RESET       2'h3
`define WDT_BASE_LOG2       16
`define WDT_GRACE_CLKS      256
`define WDT_RST_HOLD_CLKS   30
`endif

// ### hw/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_ST_COUNT,
    WDT_ST_GRACE,
    WDT_ST_RESET
  } wdt_state_t;
  typedef struct packed {
    logic [1:0] period_sel;
    logic       dog_reset_enable;
    logic       dog_irq_enable;
    logic       global_irq_enable;
  } wdt_cfg_t;
endpackage
`default_nettype wire

// ### hw/wdt_divider.sv
`include "wdt_defs.svh"
`default_nettype none
module wdt_divider #(
  parameter int BASE_LOG2 = `WDT_BASE_LOG2
) (
  input  wire logic       i_clk,
  input  wire logic       i_ce,
  input  wire logic       i_clear,
  input  wire logic [1:0] i_sel,
  output logic            o_tick
);
  localparam int W = BASE_LOG2 + 5;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] lim;
  // Free-running chain; limit = 1,4,16,32 x base
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      cnt_reg <= '0;
    end else if (i_ce) begin
      cnt_reg <= (cnt_reg == lim) ? '0 : cnt_reg + 1'b1;
    end
  end
  always_comb begin
    case (i_sel)
      2'h0:    lim = W'((64'h1 << BASE_LOG2) - 1);
      2'h1:    lim = W'((64'h4 << BASE_LOG2) - 1);
      2'h2:    lim = W'((64'h10 << BASE_LOG2) - 1);
      default: lim = W'((64'h20 << BASE_LOG2) - 1);
    endcase
  end
  assign o_tick = i_ce && !i_clear && (cnt_reg == lim);
endmodule
`default_nettype wire

// ### hw/wdt_pulse.sv
`default_nettype none
module wdt_pulse #(
  parameter int LEN = 30
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  input  wire logic i_start,
  output logic      o_active,
  output logic      o_done
);
  logic [7:0] cnt_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 8'h00;
    end else if (i_ce) begin
      if (i_start) begin
        cnt_reg <= 8'(LEN);
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  assign o_active = (cnt_reg != 8'h00);
  assign o_done   = i_ce && (cnt_reg == 8'h01);
endmodule
`default_nettype wire

// ### hw/wdt_unit.sv
// Strobed register access was decided locally.
`include "wdt_defs.svh"
`default_nettype none
// Behaviour
// - Counter chain divides system clock
// - Select 1,4,16,32 x 2^16 clocks
// - Time-out sets interrupt flag bit 3
// - Reset 256 clocks later unless restarted
// - Reset lasts 30 clocks, sets cause
// - Irq needs flag, enable, global enable
// - Reset enable gates only reset
// - Restart bit restarts counter
// - Restart bit self-clears
// - Restart only effective in period 00
// - Flag stays until software, power-on or warm reset clears
// - Software set of flag interrupts
// - Flag re-sets each interval
// - Cause cleared by power-on or write
// - Software cause set no reset
// - Reset disabled leaves cause unchanged
// - Power-on reset disables watchdog
// - Dog reset keeps enable, restarts counter
// - Period select resets to 3
module wdt_unit #(
  parameter int BASE_LOG2 = `WDT_BASE_LOG2,
  parameter int GRACE     = `WDT_GRACE_CLKS,
  parameter int HOLD      = `WDT_RST_HOLD_CLKS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_sys_rst_n,
  input  wire logic       i_ce,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_dog_irq_enable,
  input  wire logic       i_global_irq_enable,
  output logic [7:0]      o_rdata,
  output logic            o_irq,
  output logic            o_sys_reset,
  output logic            o_timeout
);
  wdt_pkg::wdt_cfg_t   cfg;
  wdt_pkg::wdt_state_t state_reg;
  logic [1:0]          sel_reg;
  logic                rst_en_reg;
  logic                flag_reg;
  logic                cause_reg;
  logic [8:0]          grace_reg;
  logic [7:0]          rdata_reg;
  logic                wr_hit;
  logic                restart;
  logic                tick;
  logic                hold_active;
  logic                hold_done;
  logic                hold_start;
  logic                warm_rst;

  assign cfg.period_sel        = sel_reg;
  assign cfg.dog_reset_enable  = rst_en_reg;
  assign cfg.dog_irq_enable    = i_dog_irq_enable;
  assign cfg.global_irq_enable = i_global_irq_enable;

  assign wr_hit   = i_wr && (i_addr == `WDT_CTRL_OFS);
  // Restart honoured only in period 00; bit is a strobe, never stored
  assign restart  = i_ce && wr_hit && i_wdata[`WDT_BIT_RESTART]
                    && (sel_reg == 2'h0);
  assign warm_rst = !i_sys_rst_n || hold_active;
  assign hold_start = i_ce && (state_reg == wdt_pkg::WDT_ST_GRACE) && (grace_reg == 9'h001)
                      && !restart;

  wdt_divider #(
    .BASE_LOG2 (BASE_LOG2)
  ) u_div (
    .i_clk   (i_clk),
    .i_ce    (i_ce),
    .i_clear (!i_rst_n || restart || warm_rst),
    .i_sel   (sel_reg),
    .o_tick  (tick)
  );

  wdt_pulse #(
    .LEN (HOLD)
  ) u_hold (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_ce     (i_ce),
    .i_start  (hold_start),
    .o_active (hold_active),
    .o_done   (hold_done)
  );

  // Control bits: power-on clears enable, select goes to 3
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_reg    <= `WDT_SEL_RESET;
      rst_en_reg <= 1'b0;
    end else if (i_ce) begin
      if (!i_sys_rst_n) begin
        sel_reg <= `WDT_SEL_RESET;
      end else if (wr_hit) begin
        sel_reg    <= {i_wdata[`WDT_BIT_SEL_HI], i_wdata[`WDT_BIT_SEL_LO]};
        rst_en_reg <= i_wdata[`WDT_BIT_RST_EN];
      end
    end
  end

  // Interrupt flag: time-out sets, set wins over software clear, warm reset clear wins over set
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else if (i_ce) begin
      if (warm_rst) begin
        flag_reg <= 1'b0;
      end else if (tick) begin
        flag_reg <= 1'b1;
      end else if (wr_hit) begin
        flag_reg <= i_wdata[`WDT_BIT_IRQ_FLAG];
      end
    end
  end

  // Reset cause: only power-on or software clears it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cause_reg <= 1'b0;
    end else if (i_ce) begin
      if (hold_start) begin
        cause_reg <= 1'b1;
      end else if (wr_hit) begin
        cause_reg <= i_wdata[`WDT_BIT_CAUSE];
      end
    end
  end

  // Grace window then reset hold
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= wdt_pkg::WDT_ST_COUNT;
      grace_reg <= 9'h000;
    end else if (i_ce) begin
      case (state_reg)
        wdt_pkg::WDT_ST_COUNT: begin
          if (tick && rst_en_reg && !warm_rst) begin
            state_reg <= wdt_pkg::WDT_ST_GRACE;
            grace_reg <= 9'(GRACE);
          end
        end
        wdt_pkg::WDT_ST_GRACE: begin
          if (restart || !rst_en_reg || !i_sys_rst_n) begin
            state_reg <= wdt_pkg::WDT_ST_COUNT;
          end else if (hold_start) begin
            state_reg <= wdt_pkg::WDT_ST_RESET;
          end else begin
            grace_reg <= grace_reg - 9'h001;
          end
        end
        wdt_pkg::WDT_ST_RESET: begin
          if (hold_done) begin
            state_reg <= wdt_pkg::WDT_ST_COUNT;
          end
        end
        default: state_reg <= wdt_pkg::WDT_ST_COUNT;
      endcase
    end
  end

  // Read data one cycle after strobe; restart reads 0
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= 8'h00;
    end else if (i_ce) begin
      if (i_rd && (i_addr == `WDT_CTRL_OFS)) begin
        rdata_reg <= {cfg.period_sel, 2'b00, flag_reg, cause_reg, cfg.dog_reset_enable, 1'b0};
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign o_rdata     = rdata_reg;
  assign o_irq       = flag_reg && cfg.dog_irq_enable && cfg.global_irq_enable;
  assign o_sys_reset = hold_active;
  assign o_timeout   = tick;
endmodule
`default_nettype wire

// ### verification/wdt_checker.sv
`default_nettype none
module wdt_checker #(
  parameter int GRACE = 256,
  parameter int HOLD  = 30
) (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_sys_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_dog_irq_enable,
  input wire logic       i_global_irq_enable,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       o_sys_reset,
  input wire logic       o_timeout
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_irq_gate: assert property (o_irq |-> i_dog_irq_enable && i_global_irq_enable)
    else $error("irq without enables");
  a_rdata_idle: assert property (!($past(i_rd) && $past(i_addr) == 8'hD8) |-> o_rdata == 8'h00)
    else $error("rdata not idle");
  a_rdata_fixed: assert property ($past(i_rd) |-> o_rdata[5:4] == 2'h0 && !o_rdata[0])
    else $error("rdata fixed bits");
  a_tick_pulse: assert property (o_timeout |=> !o_timeout)
    else $error("timeout too long");
  a_reset_delay: assert property ($rose(o_sys_reset) |-> $past(o_timeout, GRACE + 1))
    else $error("reset delay");
  a_reset_len: assert property ($fell(o_sys_reset) |-> $past(o_sys_reset, HOLD) && !$past(o_sys_reset, HOLD + 1))
    else $error("reset length");
  a_por_quiet: assert property ($rose(i_rst_n) |-> !o_sys_reset && !o_irq)
    else $error("outputs after power reset");
  a_warm_irq: assert property (!i_sys_rst_n |=> !o_irq)
    else $error("irq after warm reset");
  c_reset: cover property ($rose(o_sys_reset));
  c_irq: cover property (o_irq);
  c_tick: cover property (o_timeout);
endmodule
bind wdt_unit wdt_checker #(.GRACE(GRACE), .HOLD(HOLD)) u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sys_rst_n(i_sys_rst_n), .i_addr(i_addr), .i_rd(i_rd), .i_dog_irq_enable(i_dog_irq_enable),
  .i_global_irq_enable(i_global_irq_enable), .o_rdata(o_rdata), .o_irq(o_irq), .o_sys_reset(o_sys_reset),
  .o_timeout(o_timeout));
`default_nettype wire

// ### verification/test_watchdog_timer_unit.sv
`default_nettype none
module test_watchdog_timer_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0, i_rst_n = 0, ext_n = 1, i_wr = 0, i_rd = 0, den = 0, gen = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  wire  [7:0] o_rdata;
  wire        o_irq, o_sys_reset, o_timeout;
  int         n_errors = 0, tests_run = 0, n_rst = 0;
  int         mul[4] = '{1, 4, 16, 32};
  wdt_unit #(.BASE_LOG2(4)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sys_rst_n(ext_n & ~o_sys_reset),
    .i_ce(1'h1), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_dog_irq_enable(den),
    .i_global_irq_enable(gen), .o_rdata(o_rdata), .o_irq(o_irq), .o_sys_reset(o_sys_reset),
    .o_timeout(o_timeout));
  initial forever #4 i_clk = ~i_clk;
  always @(posedge i_clk) n_rst += o_sys_reset;
  task automatic cmp(string s, logic [15:0] e, logic [15:0] v);
    tests_run++;
    if (v !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic wr(logic [7:0] d, logic [7:0] a = 8'hD8);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'h1;
    @(posedge i_clk);
    i_wr    <= 1'h0;
  endtask
  task automatic rd(logic [7:0] e, logic [7:0] a = 8'hD8);
    i_addr <= a;
    i_rd   <= 1'h1;
    @(posedge i_clk);
    i_rd   <= 1'h0;
    @(negedge i_clk);
    cmp("rdata", 16'(e), 16'(o_rdata));
    @(posedge i_clk);
  endtask
  task automatic tick(output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (o_timeout !== 1'h1 && c < 2000);
    if (c >= 2000) n_errors++;
    @(posedge i_clk);
  endtask
  task automatic t_reset;
    rd(8'hC0);
    wr(8'hFF, 8'h10);
    rd(8'hC0);
    rd(8'h00, 8'h10);
  endtask
  task automatic t_period;
    int c;
    for (int m = 0; m < 4; m++) begin
      wr({2'(m), 6'h00});
      tick(c);
      tick(c);
      cmp("interval", 16'(mul[m] * 16), 16'(c));
    end
  endtask
  task automatic t_flag;
    rd(8'hC8);
    cmp("irq", 16'h0, o_irq);
    den <= 1'h1;
    @(posedge i_clk);
    cmp("irq", 16'h0, o_irq);
    gen <= 1'h1;
    @(posedge i_clk);
    cmp("irq", 16'h1, o_irq);
    wr(8'hC0);
    @(posedge i_clk);
    cmp("irq", 16'h0, o_irq);
    wr(8'hC8);
    @(posedge i_clk);
    cmp("irq", 16'h1, o_irq);
    den <= 1'h0;
  endtask
  task automatic t_feed(logic [1:0] s, logic e);
    int n0;
    n0 = n_rst;
    wr({s, 6'h02});
    repeat (50) begin
      repeat (6) @(posedge i_clk);
      if (n_rst == n0) wr({s, 6'h03});
      else @(posedge i_clk);
    end
    cmp("reset", 16'(e), 16'(n_rst > n0));
  endtask
  task automatic t_cause;
    int c;
    c = 0;
    while (o_sys_reset !== 1'h1 && c < 1000) begin
      @(posedge i_clk);
      c++;
    end
    while (o_sys_reset === 1'h1 && c < 1100) begin
      @(posedge i_clk);
      c++;
    end
    if (c >= 1000) n_errors++;
    rd(8'hC6);
    wr(8'h04);
    c = n_rst;
    repeat (300) @(posedge i_clk);
    cmp("reset", 16'h0, 16'(n_rst - c));
    rd(8'h0C);
    ext_n <= 1'h0;
    @(posedge i_clk);
    ext_n <= 1'h1;
    @(posedge i_clk);
    rd(8'hC4);
    i_rst_n <= 1'h0;
    @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    rd(8'hC0);
  endtask
  task automatic results;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'h1;
    t_reset;
    t_period;
    t_flag;
    t_feed(2'h0, 1'h0);
    t_feed(2'h1, 1'h1);
    t_cause;
    results;
  end
  initial begin
    #100000;
    n_errors++;
    results;
  end
endmodule
`default_nettype wire
